// ===== common/eas_pkg.sv
/*
 * Shared constants and types of the event/action sequencer: table size, widths of the
 * configuration fields, layout of the boolean source pool and the operator encodings.
 * Assumes a single clock domain; the drive control core owns every input source but the digitalIn pins, and every action.
 */
package eas_pkg;

	// Table size and field widths.
	localparam int EAS_NUM_ENTRIES = 20;
	localparam int EAS_IDX_W = 5;
	localparam int EAS_LEN_W = 5;
	localparam int EAS_ACT_W = 8;
	localparam int EAS_SEL_W = 6;
	localparam int EAS_POOL_W = 64;

	// Boolean sources that feed the pool, and the drive variables that the comparators read.
	localparam int EAS_N_STATUS = 16;
	localparam int EAS_N_DIN = 8;
	localparam int EAS_N_TIMER = 8;
	localparam int EAS_N_CMP = 4;
	localparam int EAS_N_RULE = 4;
	localparam int EAS_N_VAR = 4;
	localparam int EAS_VAR_W = 16;
	localparam int EAS_VSEL_W = 2;

	// Pool bit positions.
	localparam int EAS_POOL_FALSE = 0;
	localparam int EAS_POOL_TRUE = 1;
	localparam int EAS_POOL_STATUS = 2;
	localparam int EAS_POOL_DIN = EAS_POOL_STATUS + EAS_N_STATUS;
	localparam int EAS_POOL_TIMER = EAS_POOL_DIN + EAS_N_DIN;
	localparam int EAS_POOL_CMP = EAS_POOL_TIMER + EAS_N_TIMER;
	localparam int EAS_POOL_RULE = EAS_POOL_CMP + EAS_N_CMP;
	localparam int EAS_POOL_FIRED = EAS_POOL_RULE + EAS_N_RULE;
	localparam int EAS_POOL_USED = EAS_POOL_FIRED + 1;

	// Comparator and logic operators.
	typedef enum logic [1:0] {EAS_CMP_LT, EAS_CMP_GT, EAS_CMP_EQ, EAS_CMP_NE} eas_cmp_op_t;
	typedef enum logic [1:0] {EAS_LOP_AND, EAS_LOP_OR, EAS_LOP_ANDNOT, EAS_LOP_ORNOT} eas_lop_t;

endpackage

// ===== core/eas_event_action_sequencer.sv
/*
 * Event/action sequencer: a table of numbered event/action pairs walked one pair at a
 * time on each scan tick, with comparators and three-input logic rules as event sources.
 * Assumes statusBits, timerDone, varIn, scanTick and the configuration ports come from
 * logic on clk; digitalIn comes from pins and is synchronised here.
 */
`timescale 1ns/1ps

// Summary of operation
// [RULE1] Events and actions are stored as indexed pairs; a true event fires its action.
// [RULE2] After an action fires, the pointer moves to the following event.
// [RULE3] Only the one event under the pointer is tested at any time.
// [RULE4] A false event does nothing that scan; the pointer stays put.
// [RULE5] On start only entry zero is tested until it holds, then action zero fires.
// [RULE6] The table length is programmable from one to twenty pairs.
// [RULE7] After the last programmed pair fires, the pointer wraps to entry zero.
// [RULE8] An event selects a status bit, a logic rule output or a comparator result.
// [RULE9] Each comparator tests a drive variable against a fixed preset, giving a boolean.
// [RULE10] Each logic rule joins up to three pool booleans with AND, OR and NOT.
// [RULE11] Reset or stop clears the pointer to zero and drives no action.
module eas_event_action_sequencer
	import eas_pkg::*;
#(
	parameter int NUM_ENTRIES = EAS_NUM_ENTRIES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic runEnable,
	input wire logic scanTick,
	input wire logic [EAS_LEN_W-1:0] tableLen,
	input wire logic [EAS_N_STATUS-1:0] statusBits,
	input wire logic [EAS_N_DIN-1:0] digitalIn,
	input wire logic [EAS_N_TIMER-1:0] timerDone,
	input wire logic [EAS_N_VAR-1:0][EAS_VAR_W-1:0] varIn,
	input wire logic entryWe,
	input wire logic [EAS_IDX_W-1:0] entryIdx,
	input wire logic [EAS_SEL_W-1:0] entryEventSel,
	input wire logic [EAS_ACT_W-1:0] entryActionSel,
	input wire logic cmpWe,
	input wire logic [1:0] cmpIdx,
	input wire logic [EAS_VSEL_W-1:0] cmpVarSel,
	input wire eas_cmp_op_t cmpOp,
	input wire logic [EAS_VAR_W-1:0] cmpPreset,
	input wire logic ruleWe,
	input wire logic [1:0] ruleIdx,
	input wire logic [2:0][EAS_SEL_W-1:0] ruleInSel,
	input wire eas_lop_t ruleOp1,
	input wire eas_lop_t ruleOp2,
	output logic running,
	output logic [EAS_IDX_W-1:0] eventPointer,
	output logic actionValid,
	output logic [EAS_ACT_W-1:0] actionCode,
	output logic [EAS_IDX_W-1:0] actionIndex
);

	typedef struct packed {
		logic [1:0][EAS_N_DIN-1:0] dinSync;
		logic [NUM_ENTRIES-1:0][EAS_SEL_W-1:0] evtSel;
		logic [NUM_ENTRIES-1:0][EAS_ACT_W-1:0] actSel;
		logic [EAS_N_CMP-1:0][EAS_VSEL_W-1:0] cmpVar;
		eas_cmp_op_t [EAS_N_CMP-1:0] cmpOp;
		logic [EAS_N_CMP-1:0][EAS_VAR_W-1:0] cmpPreset;
		logic [EAS_N_RULE-1:0][2:0][EAS_SEL_W-1:0] ruleIn;
		eas_lop_t [EAS_N_RULE-1:0] ruleOpA;
		eas_lop_t [EAS_N_RULE-1:0] ruleOpB;
		logic [EAS_N_CMP-1:0] cmpRes;
		logic [EAS_N_RULE-1:0] ruleRes;
		logic [EAS_IDX_W-1:0] ptr;
		logic running;
		logic actValid;
		logic [EAS_ACT_W-1:0] actCode;
		logic [EAS_IDX_W-1:0] actIdx;
		logic fired;
	} eas_state_t;

	eas_state_t s_q;
	eas_state_t s_d;
	logic [EAS_POOL_W-1:0] pool;
	logic [EAS_IDX_W-1:0] lastIdx;
	logic active;
	logic eventTrue;
	logic fire;

	function automatic logic applyOp(input eas_lop_t op, input logic a, input logic b);
		case (op)
			EAS_LOP_AND: applyOp = a & b;
			EAS_LOP_OR: applyOp = a | b;
			EAS_LOP_ANDNOT: applyOp = a & ~b;
			EAS_LOP_ORNOT: applyOp = a | ~b;
			default: applyOp = 1'b0;
		endcase
	endfunction

	function automatic logic compare(input eas_cmp_op_t op, input logic [EAS_VAR_W-1:0] v,
			input logic [EAS_VAR_W-1:0] p);
		case (op)
			EAS_CMP_LT: compare = v < p;
			EAS_CMP_GT: compare = v > p;
			EAS_CMP_EQ: compare = v == p;
			EAS_CMP_NE: compare = v != p;
			default: compare = 1'b0;
		endcase
	endfunction

	// All event sources sit in one pool so that events and rules share one selector format.
	assign pool = {{(EAS_POOL_W-EAS_POOL_USED){1'b0}}, s_q.fired, s_q.ruleRes, s_q.cmpRes,
		timerDone, s_q.dinSync[1], statusBits, 1'b1, 1'b0}; // RULE8

	// A length of zero is read as one and anything past the table as the full table.
	assign lastIdx = (tableLen == '0) ? '0 :
		(tableLen > EAS_LEN_W'(NUM_ENTRIES)) ? EAS_IDX_W'(NUM_ENTRIES - 1) :
		EAS_IDX_W'(tableLen - 1'b1); // RULE6
	assign active = s_q.running & runEnable;
	assign eventTrue = pool[s_q.evtSel[s_q.ptr]]; // RULE3
	// Without a true event nothing below raises an action; only a stop or a shortened table moves the pointer.
	assign fire = active & scanTick & eventTrue; // RULE1 RULE4

	always_comb begin
		s_d = s_q;
		// The first stage feeds only the second; metastability settles there.
		s_d.dinSync[0] = digitalIn;
		s_d.dinSync[1] = s_q.dinSync[0];

		if (entryWe && entryIdx < EAS_IDX_W'(NUM_ENTRIES)) begin
			s_d.evtSel[entryIdx] = entryEventSel;
			s_d.actSel[entryIdx] = entryActionSel;
		end
		if (cmpWe) begin
			s_d.cmpVar[cmpIdx] = cmpVarSel;
			s_d.cmpOp[cmpIdx] = cmpOp;
			s_d.cmpPreset[cmpIdx] = cmpPreset;
		end
		if (ruleWe) begin
			s_d.ruleIn[ruleIdx] = ruleInSel;
			s_d.ruleOpA[ruleIdx] = ruleOp1;
			s_d.ruleOpB[ruleIdx] = ruleOp2;
		end

		for (int c = 0; c < EAS_N_CMP; c++) begin
			s_d.cmpRes[c] = compare(s_q.cmpOp[c], varIn[s_q.cmpVar[c]], s_q.cmpPreset[c]); // RULE9
		end
		// Rules read registered pool bits, so chained rules settle one cycle per stage.
		for (int r = 0; r < EAS_N_RULE; r++) begin
			s_d.ruleRes[r] = applyOp(s_q.ruleOpB[r],
				applyOp(s_q.ruleOpA[r], pool[s_q.ruleIn[r][0]], pool[s_q.ruleIn[r][1]]),
				pool[s_q.ruleIn[r][2]]); // RULE10
		end

		s_d.running = runEnable;
		s_d.actValid = 1'b0;
		if (scanTick) begin
			s_d.fired = 1'b0;
		end
		if (!active) begin
			s_d.ptr = '0; // RULE11 RULE5
			s_d.fired = 1'b0;
		end else if (fire) begin
			s_d.actValid = 1'b1; // RULE1
			s_d.actCode = s_q.actSel[s_q.ptr];
			s_d.actIdx = s_q.ptr;
			s_d.fired = 1'b1;
			if (s_q.ptr >= lastIdx) begin
				s_d.ptr = '0; // RULE7
			end else begin
				s_d.ptr = s_q.ptr + 1'b1; // RULE2
			end
		end else if (s_q.ptr > lastIdx) begin
			// The table was shortened under a running pointer; restart the walk.
			s_d.ptr = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0; // RULE11
		end else begin
			s_q <= s_d;
		end
	end

	assign running = s_q.running;
	assign eventPointer = s_q.ptr;
	assign actionValid = s_q.actValid;
	assign actionCode = s_q.actCode;
	assign actionIndex = s_q.actIdx;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_false_holds: assert property (active && scanTick && !eventTrue && s_q.ptr <= lastIdx
		|=> $stable(s_q.ptr) && !s_q.actValid) // RULE4
		else $error("pointer moved or action fired on a false event");

	a_fire_pairs: assert property (fire |=> s_q.actValid && s_q.actIdx == $past(s_q.ptr)
		&& s_q.actCode == $past(s_q.actSel[s_q.ptr])) // RULE1
		else $error("fired action does not match the pointed entry");

	a_advance_ptr: assert property (fire && s_q.ptr < lastIdx
		|=> s_q.ptr == $past(s_q.ptr) + 1'b1) // RULE2
		else $error("pointer did not advance after an action");

	a_wrap_zero: assert property (fire && s_q.ptr == lastIdx |=> s_q.ptr == '0) // RULE7
		else $error("pointer did not wrap after the last entry");

	a_stop_clears: assert property (!runEnable |=> s_q.ptr == '0 && !s_q.actValid) // RULE11
		else $error("stopped sequencer kept pointer or drove an action");

	a_start_entry0: assert property ($rose(s_q.running) |-> s_q.ptr == '0
		##1 (s_q.ptr == '0 || $past(fire))) // RULE5
		else $error("sequencer left entry zero without firing it");

	a_single_event: assert property (!scanTick |=> !s_q.actValid) // RULE3
		else $error("action fired without a scan tick");

	a_ptr_range: assert property (s_q.ptr <= lastIdx || $past(tableLen) != tableLen
		|| $past(rst)) // RULE6
		else $error("pointer beyond programmed table length");

	a_din_sync: assert property (s_q.dinSync[1] == $past(digitalIn, 2)) // RULE8
		else $error("digital input not delayed by two stages");

	a_cmp_result: assert property (##1 s_q.cmpRes[0] == $past(compare(s_q.cmpOp[0],
		varIn[s_q.cmpVar[0]], s_q.cmpPreset[0]))) // RULE9
		else $error("comparator result wrong");

	// The run flag is a plain copy of the enable, one cycle late, so a tick in
	// the first cycle after start is refused and entry zero is the first tested.
	// A user who pulses the tick together with the enable loses that tick.
	a_running_copy: assert property (!rst
		|=> s_q.running == $past(runEnable)) // RULE11
		else $error("run flag does not follow the enable");

	a_stop_running: assert property (!runEnable
		|=> !s_q.running) // RULE11
		else $error("run flag stayed high after stop");

	a_idle_quiet: assert property (!active
		|=> !s_q.actValid) // RULE11
		else $error("action driven while stopped");

	a_tick_refused: assert property (!s_q.running
		|=> !s_q.actValid) // RULE5
		else $error("tick taken before the sequencer was running");

	// Between scan ticks the pointer and the last action must stand still.
	// Only a shortened table or a stop may move the pointer without a tick.
	a_ptr_notick: assert property (active && !scanTick && s_q.ptr <= lastIdx
		|=> $stable(s_q.ptr)) // RULE4
		else $error("pointer moved without a scan tick");

	a_code_holds: assert property (!fire
		|=> $stable(s_q.actCode) && $stable(s_q.actIdx)) // RULE1
		else $error("action code or index changed without a fire");

	a_valid_source: assert property (s_q.actValid
		|-> $past(fire)) // RULE1
		else $error("action pulse without a true event");

	a_len_one: assert property (active && scanTick && lastIdx == '0
		|=> s_q.ptr == '0) // RULE6
		else $error("single-entry table left entry zero");

	a_ptr_bound: assert property (s_q.ptr
		< EAS_IDX_W'(NUM_ENTRIES)) // RULE6
		else $error("pointer outside the table");

	// Configuration writes take effect on the next cycle; a late write would let
	// an event be judged against a stale selector.
	a_entry_write: assert property (entryWe && entryIdx < EAS_IDX_W'(NUM_ENTRIES)
		|=> s_q.evtSel[$past(entryIdx)] == $past(entryEventSel)
		&& s_q.actSel[$past(entryIdx)] == $past(entryActionSel)) // RULE1
		else $error("entry write did not land");

	a_cmp_write: assert property (cmpWe
		|=> s_q.cmpPreset[$past(cmpIdx)] == $past(cmpPreset)) // RULE9
		else $error("comparator preset write did not land");

	a_cmp_opwrite: assert property (cmpWe
		|=> s_q.cmpOp[$past(cmpIdx)] == $past(cmpOp)) // RULE9
		else $error("comparator operator write did not land");

	a_rule_write: assert property (ruleWe
		|=> s_q.ruleIn[$past(ruleIdx)] == $past(ruleInSel)) // RULE10
		else $error("rule input write did not land");

	a_rule_ops: assert property (ruleWe
		|=> s_q.ruleOpA[$past(ruleIdx)] == $past(ruleOp1)
		&& s_q.ruleOpB[$past(ruleIdx)] == $past(ruleOp2)) // RULE10
		else $error("rule operator write did not land");

	// The fired flag lets a rule see an event; a fire in the tick cycle wins.
	a_fired_flag: assert property (fire
		|=> s_q.fired) // RULE10
		else $error("fired flag not set after an action");

	a_din_stage1: assert property (!rst
		|=> s_q.dinSync[0] == $past(digitalIn)) // RULE8
		else $error("first input stage missed the pin");

	c_fire_entry0: cover property ($rose(s_q.running) ##[1:50] (fire && s_q.ptr == '0));
	c_wrap: cover property (fire && s_q.ptr == lastIdx && lastIdx == 5'h03);
	c_false_scan: cover property (active && scanTick && !eventTrue ##[1:20] fire);
	c_rule_true: cover property (s_q.ruleRes[0] && s_q.evtSel[s_q.ptr] == 6'(EAS_POOL_RULE));
	c_len_one: cover property (fire && lastIdx == '0);

endmodule // eas_event_action_sequencer

// ===== bench/eas_drive_model.sv
/*
 * Behavioural drive control core: registers the status booleans that the bench asks for
 * and executes each fired action by recording its code and counting it.
 * Assumes one clock, synchronous active-high reset, actions as one-cycle pulses.
 */
`timescale 1ns/1ps
module eas_drive_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic actionValid,
	input wire logic [7:0] actionCode,
	input wire logic [15:0] statusReq,
	output logic [15:0] statusBits,
	output logic [7:0] lastAction,
	output int actionCount
);
	// Status comes from a register, as in the real core, so it lags the request by a cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			statusBits <= 16'h0000;
			lastAction <= 8'h00;
			actionCount <= 0;
		end else begin
			statusBits <= statusReq;
			if (actionValid) begin
				lastAction <= actionCode;
				actionCount <= actionCount + 1;
			end
		end
	end
endmodule // eas_drive_model

// ===== bench/eas_event_action_sequencer_bench.sv
/*
 * Self-checking bench of the event/action sequencer with a drive core model.
 * Assumes the design's contract: one evaluation per scan tick, answer one cycle later.
 */
`timescale 1ns/1ps
module eas_event_action_sequencer_bench import eas_pkg::*; ;
	logic clk, rst, runEnable, scanTick, entryWe, cmpWe, ruleWe, running, actionValid;
	logic [4:0] tableLen, entryIdx, eventPointer, actionIndex;
	logic [15:0] statusReq, statusBits, cmpPreset;
	logic [3:0][15:0] varIn;
	logic [5:0] entryEventSel;
	logic [7:0] entryActionSel, actionCode, lastAction, digitalIn;
	logic [1:0] cmpIdx, ruleIdx, cmpVarSel;
	logic [2:0][5:0] ruleInSel;
	eas_cmp_op_t cmpOp;
	eas_lop_t ruleOp1, ruleOp2;
	int actionCount, errors, samplesChecked, cycles;
	eas_event_action_sequencer eas_event_action_sequencer_i (.clk(clk), .rst(rst),
		.runEnable(runEnable), .scanTick(scanTick), .tableLen(tableLen),
		.statusBits(statusBits), .digitalIn(digitalIn), .timerDone(8'h00), .varIn(varIn),
		.entryWe(entryWe), .entryIdx(entryIdx), .entryEventSel(entryEventSel),
		.entryActionSel(entryActionSel), .cmpWe(cmpWe), .cmpIdx(cmpIdx),
		.cmpVarSel(cmpVarSel), .cmpOp(cmpOp), .cmpPreset(cmpPreset), .ruleWe(ruleWe),
		.ruleIdx(ruleIdx), .ruleInSel(ruleInSel), .ruleOp1(ruleOp1), .ruleOp2(ruleOp2),
		.running(running), .eventPointer(eventPointer), .actionValid(actionValid),
		.actionCode(actionCode), .actionIndex(actionIndex));
	eas_drive_model eas_drive_model_i (.clk(clk), .rst(rst), .actionValid(actionValid),
		.actionCode(actionCode), .statusReq(statusReq), .statusBits(statusBits),
		.lastAction(lastAction), .actionCount(actionCount));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task results();
		$display("errors %0d samples checked %0d", errors, samplesChecked);
		if (errors == 0 && samplesChecked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// A hang is cut short well past the 85 or so cycles the scenarios need.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			results();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task settle();
		repeat (3) @(posedge clk);
	endtask
	task wr(input logic [4:0] idx, input logic [5:0] sel, input logic [7:0] act);
		@(posedge clk);
		entryWe <= 1'b1;
		entryIdx <= idx;
		entryEventSel <= sel;
		entryActionSel <= act;
		@(posedge clk);
		entryWe <= 1'b0;
	endtask
	// The answer of a scan is looked at just after the edge that follows the tick.
	task scan(input logic f, input logic [4:0] idx, input logic [7:0] code,
		input logic [4:0] ptr);
		@(posedge clk);
		scanTick <= 1'b1;
		@(posedge clk);
		scanTick <= 1'b0;
		#1;
		chk(16'(actionValid), 16'(f));
		if (f) begin
			chk(16'(actionIndex), 16'(idx));
			chk(16'(actionCode), 16'(code));
		end
		chk(16'(eventPointer), 16'(ptr));
	endtask
	task t_walk();
		wr(5'h00, 6'h02, 8'ha0);
		wr(5'h01, 6'h03, 8'ha1);
		wr(5'h02, 6'h04, 8'ha2);
		tableLen <= 5'h03;
		runEnable <= 1'b1;
		settle();
		scan(1'b0, 5'h00, 8'h00, 5'h00);
		statusReq <= 16'h0004;
		settle();
		scan(1'b0, 5'h00, 8'h00, 5'h00);
		statusReq <= 16'h0007;
		settle();
		scan(1'b1, 5'h00, 8'ha0, 5'h01);
		scan(1'b1, 5'h01, 8'ha1, 5'h02);
		scan(1'b1, 5'h02, 8'ha2, 5'h00);
		@(posedge clk);
		#1;
		chk(16'(actionCount), 16'h0003);
	endtask
	task t_len1();
		tableLen <= 5'h01;
		settle();
		scan(1'b1, 5'h00, 8'ha0, 5'h00);
		scan(1'b1, 5'h00, 8'ha0, 5'h00);
	endtask
	task t_cmp();
		@(posedge clk);
		cmpWe <= 1'b1;
		cmpOp <= EAS_CMP_GT;
		cmpPreset <= 16'h0100;
		varIn[0] <= 16'h0100;
		@(posedge clk);
		cmpWe <= 1'b0;
		wr(5'h00, 6'h22, 8'h5c);
		settle();
		scan(1'b0, 5'h00, 8'h00, 5'h00);
		varIn[0] <= 16'h0101;
		settle();
		scan(1'b1, 5'h00, 8'h5c, 5'h00);
	endtask
	task t_din();
		wr(5'h00, 6'h12, 8'h3c);
		settle();
		scan(1'b0, 5'h00, 8'h00, 5'h00);
		digitalIn <= 8'h01;
		settle();
		scan(1'b1, 5'h00, 8'h3c, 5'h00);
		digitalIn <= 8'h00;
	endtask
	task t_rule();
		@(posedge clk);
		ruleWe <= 1'b1;
		ruleInSel <= {6'h01, 6'h03, 6'h02};
		ruleOp1 <= EAS_LOP_ANDNOT;
		ruleOp2 <= EAS_LOP_AND;
		@(posedge clk);
		ruleWe <= 1'b0;
		wr(5'h00, 6'h26, 8'h7e);
		statusReq <= 16'h0003;
		settle();
		scan(1'b0, 5'h00, 8'h00, 5'h00);
		statusReq <= 16'h0001;
		settle();
		scan(1'b1, 5'h00, 8'h7e, 5'h00);
	endtask
	task t_stop();
		statusReq <= 16'h0001;
		tableLen <= 5'h03;
		settle();
		scan(1'b1, 5'h00, 8'h7e, 5'h01);
		runEnable <= 1'b0;
		settle();
		chk(16'(eventPointer), 16'h0000);
		chk(16'(running), 16'h0000);
		scan(1'b0, 5'h00, 8'h00, 5'h00);
	endtask
	initial begin
		rst = 1'b1;
		{runEnable, scanTick, entryWe, cmpWe, ruleWe} = 5'h00;
		{tableLen, entryIdx, entryEventSel, entryActionSel} = '0;
		{cmpIdx, cmpVarSel, cmpPreset, ruleIdx, ruleInSel} = '0;
		cmpOp = EAS_CMP_LT;
		ruleOp1 = EAS_LOP_AND;
		ruleOp2 = EAS_LOP_AND;
		varIn = '0;
		statusReq = 16'h0000;
		digitalIn = 8'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(16'(eventPointer), 16'h0000);
		chk(16'(actionValid), 16'h0000);
		t_walk();
		t_len1();
		t_cmp();
		t_din();
		t_rule();
		t_stop();
		results();
	end
endmodule // eas_event_action_sequencer_bench
